//--- bench/lamp_stage_model.sv
// Purpose: Behavioural model of the three lamp output stages behind the PWM gates
// Assumes: Gate high means the stage is switched on
// Notes:   Underload is only sensed while a stage is on, as a real stage would
module lamp_stage_model (
  input  wire logic       clk_in,
  input  wire logic [2:0] gate_in,
  input  wire logic [2:0] open_load_in,
  output logic      [2:0] underload_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // An open load cannot be seen while the stage is off, so gate the event
  always_ff @(posedge clk_in) begin
    underload_out <= gate_in & open_load_in;
  end
endmodule

//--- bench/tb_top.sv
// Purpose: Self-checking bench for the lamp PWM register and flag block
// Assumes: Design defaults; one full PWM period is too long, so only the on-time of the first is timed
// Notes:   Register and flag checks run while the first on-step is being timed
module tb_top
  import lamp_pwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_in       = 1'b0;
  logic        sys_rst_in   = 1'b1;
  logic        reg_wr_in    = 1'b0;
  logic [5:0]  reg_addr_in  = 6'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [15:0] reg_rdata_out;
  logic [2:0]  uld;
  logic [2:0]  open_cmd     = 3'h0;
  logic        high_one     = 1'b0;
  logic        low_one      = 1'b0;
  logic        tw_raw       = 1'b0;
  logic        pwm_sel      = 1'b1;
  logic [6:0]  shared_b     = 7'h15;
  logic [6:0]  shared_cd    = 7'h2A;
  logic        lamp_b, lamp_c, lamp_d, uld_flag, tw_flag;
  int          num_errors   = 0;
  int          comparisons  = 0;

  initial forever #10 clk_in = ~clk_in;

  lamp_pwm_duty_freq_config dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .internal_pwm_select_in(pwm_sel), .shared_duty_b_in(shared_b), .shared_duty_cd_in(shared_cd),
    .underload_lamp_in(uld), .underload_high_one_in(high_one), .underload_low_one_in(low_one),
    .thermal_warning_raw_in(tw_raw), .lamp_output_b_out(lamp_b), .lamp_output_c_out(lamp_c),
    .lamp_output_d_out(lamp_d), .underload_flag_out(uld_flag), .thermal_warning_flag_out(tw_flag));

  lamp_stage_model stages (.clk_in(clk_in), .gate_in({lamp_d, lamp_c, lamp_b}),
    .open_load_in(open_cmd), .underload_out(uld));

  //////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Strobe lasts one cycle; a later call cannot collide with the release
  task automatic reg_write(logic [5:0] a, logic [15:0] d);
    @(posedge clk_in) #1 reg_wr_in = 1'b1;
    reg_addr_in  = a;
    reg_wdata_in = d;
    @(posedge clk_in) #1 reg_wr_in = 1'b0;
  endtask

  task automatic reg_read_check(logic [5:0] a, logic [15:0] exp);
    @(posedge clk_in) #1 reg_addr_in = a;
    @(posedge clk_in) #1 check("register read", exp, reg_rdata_out);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic check_registers();
    logic [5:0]  addrs [5] = '{ADDR_LAMP_B, ADDR_LAMP_C, ADDR_LAMP_D, ADDR_GLOBAL, 6'h20};
    logic [15:0] full  [5] = '{16'h83FF, 16'h83FF, 16'h83FF, 16'h403A, 16'h0000};
    foreach (addrs[i]) reg_read_check(addrs[i], 16'h0000);
    foreach (addrs[i]) reg_write(addrs[i], 16'hFFFF);
    foreach (addrs[i]) reg_read_check(addrs[i], full[i]);
  endtask

  // Each case: mask word, then open load, high one, low one, thermal, flags expected
  task automatic check_flags();
    logic [15:0] masks [7] = '{16'h0000, 16'h0002, 16'h0008, 16'h0020, 16'h0020, 16'h0010, 16'h0010};
    logic [5:0]  cases [7] = '{6'h27, 6'h20, 6'h16, 6'h10, 6'h0A, 6'h08, 6'h12};
    foreach (masks[i]) begin
      reg_write(ADDR_GLOBAL, masks[i]);
      open_cmd = {3{cases[i][5]}};
      {high_one, low_one, tw_raw} = cases[i][4:2];
      repeat (3) @(posedge clk_in);
      #1 check("underload flag", {15'h0000, cases[i][1]}, {15'h0000, uld_flag});
      check("thermal flag", {15'h0000, cases[i][0]}, {15'h0000, tw_flag});
    end
    open_cmd = 3'h0;
    {high_one, low_one, tw_raw} = 3'h0;
  endtask

  // Shadow is zero after reset, so coarse code 0 at the slow rate: eight steps on,
  // and the fine settings written meanwhile must not cut in before the period ends
  task automatic measure_first_period();
    int n = 0;
    int nb = 0;
    int nc = 0;
    int nd = 0;
    while (lamp_b !== 1'b1 && n < 20) begin
      @(posedge clk_in) #1 n++;
    end
    if (n == 20) begin
      num_errors++;
      $display("ERROR lamp b rise expected high seen timeout");
      conclude();
    end
    while (lamp_b === 1'b1 && nb < 4000) begin
      nb++;
      nc += int'(lamp_c === 1'b1);
      nd += int'(lamp_d === 1'b1);
      @(posedge clk_in) #1;
    end
    check("lamp b on cycles", 16'((1 << COARSE_SHIFT) * STEP_LOW), 16'(nb));
    check("lamp c on cycles", 16'((1 << COARSE_SHIFT) * STEP_LOW), 16'(nc));
    check("lamp d on cycles", 16'((1 << COARSE_SHIFT) * STEP_LOW), 16'(nd));
  endtask

  // Mid-run reset clears the global and lamp b registers as read back; dropping the select gates the lamps one cycle later
  task automatic check_reset_and_select();
    @(posedge clk_in) #1 sys_rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    reg_read_check(ADDR_GLOBAL, GLOBAL_RESET);
    reg_read_check(ADDR_LAMP_B, LAMP_RESET);
    check("lamp outputs after reset", 16'h0007, {13'h0000, lamp_d, lamp_c, lamp_b});
    @(posedge clk_in) #1 pwm_sel = 1'b0;
    repeat (2) @(posedge clk_in);
    #1 check("lamp outputs deselected", 16'h0000, {13'h0000, lamp_d, lamp_c, lamp_b});
    pwm_sel = 1'b1;
    @(posedge clk_in) #1 check("lamp outputs reselected", 16'h0007, {13'h0000, lamp_d, lamp_c, lamp_b});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    fork
      measure_first_period();
      begin
        check_registers();
        check_flags();
      end
    join
    check_reset_and_select();
    conclude();
  end
endmodule

//--- logic/lamp_pwm_channel.sv
// Purpose: One PWM channel with period-aligned loading of duty, rate and resolution
// Assumes: Setting inputs come from logic on the same clock
// Notes:   Output is off from the cycle after enable goes low
module lamp_pwm_channel
  import lamp_pwm_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          sys_rst_in,
  input  wire logic          enable_in,
  input  wire logic          fine_in,
  input  wire lamp_setting_t setting_in,
  output logic               pwm_out,
  output logic               period_start_out
);

  logic [PRE_W-1:0] pre;
  logic [9:0]       cnt;
  lamp_setting_t    shadow;
  logic             fine_sh;

  ////////////////////////////////////////////////////////////////////////////////
  // Step length follows the latched rate, so a period never mixes two rates
  wire logic [PRE_W-1:0] step_len  = shadow.rate ? STEP_HIGH : STEP_LOW;
  wire logic             step_end  = (pre == step_len - PRE_ONE);
  wire logic             wrap      = step_end && (cnt == CNT_TOP);
  wire logic             fine_hit  = (cnt <= shadow.duty);
  wire logic             crs_hit   = (cnt[9:COARSE_SHIFT] <= shadow.duty[6:0]);
  wire logic             next_pwm  = enable_in && (fine_sh ? fine_hit : crs_hit);

  assign period_start_out = wrap;

  // Prescaler and step counter
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pre <= PRE_ZERO;
      cnt <= CNT_ZERO;
    end else begin
      pre <= step_end ? PRE_ZERO : pre + PRE_ONE;
      cnt <= step_end ? cnt + CNT_ONE : cnt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      shadow  <= '0;
      fine_sh <= 1'b0;
    end else if (wrap) begin
      shadow  <= setting_in;
      fine_sh <= fine_in;
    end
  end

  // Registered output, high while the step count is within the duty code
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= next_pwm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_shadow_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !wrap |=> $stable(shadow) && $stable(fine_sh))
    else $error("setting changed inside a running period");

  chk_shadow_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wrap |=> shadow == $past(setting_in))
    else $error("setting not taken at period start");

endmodule

//--- logic/lamp_pwm_duty_freq_config.sv
// Purpose: Register file and internal PWM for three lamp outputs, plus global setup masks
// Assumes: Register port is driven by the serial interface logic on the same clock
// Notes:   Shared 7-bit duty codes and raw status events arrive from neighbouring logic
//
// What this block does
// - Lamp b duty is fine code plus one over 1024
// - Lamp c duty is fine code plus one over 1024
// - Lamp d duty is fine code plus one over 1024
// - Lamp b bit 15 picks 170 or 225 Hz
// - Lamp c bit 15 picks 170 or 225 Hz
// - Lamp d bit 15 picks 170 or 225 Hz
// - Global setup holds resolution and mask bits, reset zero
// - Resolution bit picks shared 7-bit or per-lamp 10-bit
// - Mask-all bit blocks every underload from global flag
// - Thermal mask bit blocks the global thermal warning
// - High and low stage masks block their own underload
module lamp_pwm_duty_freq_config
  import lamp_pwm_pkg::*;
#(
  parameter int N_ULD = 3
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             reg_wr_in,
  input  wire logic [5:0]       reg_addr_in,
  input  wire logic [15:0]      reg_wdata_in,
  output logic      [15:0]      reg_rdata_out,
  input  wire logic             internal_pwm_select_in,
  input  wire logic [6:0]       shared_duty_b_in,
  input  wire logic [6:0]       shared_duty_cd_in,
  input  wire logic [N_ULD-1:0] underload_lamp_in,
  input  wire logic             underload_high_one_in,
  input  wire logic             underload_low_one_in,
  input  wire logic             thermal_warning_raw_in,
  output logic                  lamp_output_b_out,
  output logic                  lamp_output_c_out,
  output logic                  lamp_output_d_out,
  output logic                  underload_flag_out,
  output logic                  thermal_warning_flag_out
);

  lamp_setting_t            lamp_cfg [LAMP_COUNT];
  global_setup_t            global_setup;
  lamp_setting_t            chan_set [LAMP_COUNT];
  logic [LAMP_COUNT-1:0]    chan_pwm;
  logic [LAMP_COUNT-1:0]    lamp_sel;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire logic sel_global = (reg_addr_in == ADDR_GLOBAL);
  assign lamp_sel[0]    = (reg_addr_in == ADDR_LAMP_B);
  assign lamp_sel[1]    = (reg_addr_in == ADDR_LAMP_C);
  assign lamp_sel[2]    = (reg_addr_in == ADDR_LAMP_D);

  // Write data split into lamp and global fields
  wire lamp_setting_t wr_lamp   = '{rate: reg_wdata_in[RATE_BIT], duty: reg_wdata_in[DUTY_MSB:0]};
  wire global_setup_t wr_global = '{fine:          reg_wdata_in[FINE_RES_BIT],
                                    mask_uld_high: reg_wdata_in[MASK_ULD_HIGH_BIT],
                                    mask_uld_low:  reg_wdata_in[MASK_ULD_LOW_BIT],
                                    mask_tw:       reg_wdata_in[MASK_TW_BIT],
                                    mask_uld_all:  reg_wdata_in[MASK_ULD_ALL_BIT]};

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      global_setup <= GLOBAL_RESET[4:0];
    end else if (reg_wr_in && sel_global) begin
      global_setup <= wr_global;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; reserved bits read as zero, unmapped addresses read zero
  logic [15:0] lamp_rd [LAMP_COUNT];
  wire  [15:0] global_rd = (16'(global_setup.fine)          << FINE_RES_BIT)
                         | (16'(global_setup.mask_uld_high) << MASK_ULD_HIGH_BIT)
                         | (16'(global_setup.mask_uld_low)  << MASK_ULD_LOW_BIT)
                         | (16'(global_setup.mask_tw)       << MASK_TW_BIT)
                         | (16'(global_setup.mask_uld_all)  << MASK_ULD_ALL_BIT);
  wire  [15:0] next_rdata = lamp_sel[0] ? lamp_rd[0] :
                            lamp_sel[1] ? lamp_rd[1] :
                            lamp_sel[2] ? lamp_rd[2] :
                            sel_global  ? global_rd  : 16'h0000;

  // Read data held in a flop, follows the address one cycle later
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Lamp registers and channels, one per lamp output
  wire logic [6:0] shared_duty [LAMP_COUNT];
  assign shared_duty[0] = shared_duty_b_in;
  assign shared_duty[1] = shared_duty_cd_in;
  assign shared_duty[2] = shared_duty_cd_in;

  // Channel counters keep running; its output is off from the cycle after the internal generator is deselected
  wire logic pwm_enable = internal_pwm_select_in;

  for (genvar i = 0; i < LAMP_COUNT; i++) begin : g_lamp
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        lamp_cfg[i] <= LAMP_RESET[10:0];
      end else if (reg_wr_in && lamp_sel[i]) begin
        lamp_cfg[i] <= wr_lamp;
      end
    end

    assign lamp_rd[i] = (16'(lamp_cfg[i].rate) << RATE_BIT) | 16'(lamp_cfg[i].duty);

    // duty source select
    // Fine code used only with fine resolution, else the shared coarse code
    assign chan_set[i] = global_setup.fine ? lamp_cfg[i] :
                         '{rate: lamp_cfg[i].rate, duty: {COARSE_PAD, shared_duty[i]}};

    lamp_pwm_channel u_chan (
      .clk_in           (clk_in),
      .sys_rst_in       (sys_rst_in),
      .enable_in        (pwm_enable),
      .fine_in          (global_setup.fine),
      .setting_in       (chan_set[i]),
      .pwm_out          (chan_pwm[i]),
      .period_start_out ()
    );
  end

  assign lamp_output_b_out = chan_pwm[0];
  assign lamp_output_c_out = chan_pwm[1];
  assign lamp_output_d_out = chan_pwm[2];

  ////////////////////////////////////////////////////////////////////////////////
  // per stage underload masks
  wire logic uld_high  = underload_high_one_in && !global_setup.mask_uld_high;
  wire logic uld_low   = underload_low_one_in  && !global_setup.mask_uld_low;
  // general underload mask gates every contribution
  wire logic next_uld  = !global_setup.mask_uld_all && ((|underload_lamp_in) || uld_high || uld_low);
  wire logic next_tw   = thermal_warning_raw_in && !global_setup.mask_tw;

  // Global flags are levels; the sticky status register lives elsewhere
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      underload_flag_out       <= 1'b0;
      thermal_warning_flag_out <= 1'b0;
    end else begin
      underload_flag_out       <= next_uld;
      thermal_warning_flag_out <= next_tw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence lamp_write(int k);
    reg_wr_in && lamp_sel[k];
  endsequence

  sequence global_write;
    reg_wr_in && sel_global;
  endsequence

  chk_global_reset: assert property (@(posedge clk_in)
    sys_rst_in |=> global_setup == '0 && reg_rdata_out == 16'h0000)
    else $error("global setup not cleared by reset");

  chk_global_readback: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    global_write ##1 (!reg_wr_in && sel_global) |=>
      reg_rdata_out == ($past(reg_wdata_in, 2) & 16'h403A))
    else $error("global setup readback wrong");

  chk_rate_lamp_b: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    lamp_write(0) |=> lamp_cfg[0].rate == $past(reg_wdata_in[RATE_BIT]))
    else $error("lamp b rate bit not stored");

  chk_rate_lamp_c: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    lamp_write(1) |=> lamp_cfg[1].rate == $past(reg_wdata_in[RATE_BIT]))
    else $error("lamp c rate bit not stored");

  chk_rate_lamp_d: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    lamp_write(2) |=> lamp_cfg[2].rate == $past(reg_wdata_in[RATE_BIT]))
    else $error("lamp d rate bit not stored");

  chk_fine_duty_b: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    global_setup.fine |-> chan_set[0].duty == lamp_cfg[0].duty)
    else $error("lamp b fine code not routed");

  chk_fine_duty_c: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    global_setup.fine |-> chan_set[1].duty == lamp_cfg[1].duty)
    else $error("lamp c fine code not routed");

  chk_fine_duty_d: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    global_setup.fine |-> chan_set[2].duty == lamp_cfg[2].duty)
    else $error("lamp d fine code not routed");

  chk_coarse_source: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !global_setup.fine |-> chan_set[0].duty == {COARSE_PAD, shared_duty_b_in}
                        && chan_set[1].duty == {COARSE_PAD, shared_duty_cd_in}
                        && chan_set[2].duty == {COARSE_PAD, shared_duty_cd_in})
    else $error("coarse mode not using shared code");

  chk_output_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !internal_pwm_select_in ##1 !internal_pwm_select_in |-> chan_pwm == '0)
    else $error("lamp driven without internal generator");

  chk_uld_all_mask: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    global_setup.mask_uld_all && !global_write |=> !underload_flag_out)
    else $error("underload flag set while masked");

  chk_tw_mask: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    thermal_warning_raw_in |=> thermal_warning_flag_out == !$past(global_setup.mask_tw))
    else $error("thermal flag does not follow mask");

  chk_stage_masks: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (underload_high_one_in && !underload_low_one_in && underload_lamp_in == '0 && !global_setup.mask_uld_all)
      |=> underload_flag_out == !$past(global_setup.mask_uld_high))
    else $error("high stage underload mask wrong");

endmodule

//--- logic/lamp_pwm_pkg.sv
// Purpose: Shared constants and carriers for the lamp PWM generator block
// Assumes: Register port is the internal register file port behind the serial interface
// Notes:   Step lengths derive from the system clock rate below
package lamp_pwm_pkg;

  // Register offsets
  localparam logic [5:0] ADDR_LAMP_B      = 6'h14;
  localparam logic [5:0] ADDR_LAMP_C      = 6'h15;
  localparam logic [5:0] ADDR_LAMP_D      = 6'h16;
  localparam logic [5:0] ADDR_GLOBAL      = 6'h3F;

  // Field positions in the lamp duty and rate registers
  localparam int RATE_BIT                 = 15;
  localparam int DUTY_MSB                 = 9;

  // Field positions in the global setup register
  localparam int FINE_RES_BIT             = 14;
  localparam int MASK_ULD_HIGH_BIT        = 5;
  localparam int MASK_ULD_LOW_BIT         = 4;
  localparam int MASK_TW_BIT              = 3;
  localparam int MASK_ULD_ALL_BIT         = 1;

  // Reset values
  localparam logic [15:0] LAMP_RESET      = 16'h0000;
  localparam logic [15:0] GLOBAL_RESET    = 16'h0000;

  // Timing: PWM rates and derived step lengths
  localparam int CLK_HZ                   = 50_000_000;
  localparam int RATE_LOW_HZ              = 170;
  localparam int RATE_HIGH_HZ             = 225;
  localparam int FINE_STEPS               = 1024;
  localparam int COARSE_SHIFT             = 3;
  localparam int PRE_W                    = 9;
  localparam logic [PRE_W-1:0] STEP_LOW   = PRE_W'(CLK_HZ / (RATE_LOW_HZ * FINE_STEPS));
  localparam logic [PRE_W-1:0] STEP_HIGH  = PRE_W'(CLK_HZ / (RATE_HIGH_HZ * FINE_STEPS));
  localparam logic [PRE_W-1:0] PRE_ONE    = 9'h001;
  localparam logic [PRE_W-1:0] PRE_ZERO   = 9'h000;
  localparam logic [9:0]  CNT_TOP         = 10'h3FF;
  localparam logic [9:0]  CNT_ONE         = 10'h001;
  localparam logic [9:0]  CNT_ZERO        = 10'h000;
  localparam logic [2:0]  COARSE_PAD      = 3'h0;
  localparam int LAMP_COUNT               = 3;

  // One lamp setting: rate select and duty code
  typedef struct packed {
    logic       rate;
    logic [9:0] duty;
  } lamp_setting_t;

  // Global setup fields
  typedef struct packed {
    logic fine;
    logic mask_uld_high;
    logic mask_uld_low;
    logic mask_tw;
    logic mask_uld_all;
  } global_setup_t;

endpackage
